// File: interrupt_priority_status_pkg.sv
// Constants shared by the interrupt priority and status block
package interrupt_priority_status_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_UART_ERROR_PRIORITY     = 8'h00;
  localparam logic [7:0] ADDR_VOLTAGE_DETECT_PRIORITY = 8'h04;
  localparam logic [7:0] ADDR_WAKEUP_PRIORITY         = 8'h08;
  localparam logic [7:0] ADDR_INTERRUPT_STATUS_VECTOR = 8'h0c;
  localparam logic [7:0] ADDR_INTERRUPT_CONTROL_ONE   = 8'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SECOND_UART_ERROR_LEVEL_POS = 8;
  localparam int FIRST_UART_ERROR_LEVEL_POS  = 4;
  localparam int VOLTAGE_DETECT_LEVEL_POS    = 0;
  localparam int LOW_POWER_WAKEUP_LEVEL_POS  = 0;
  localparam int REQUEST_UNACKNOWLEDGED_POS  = 15;
  localparam int VECTOR_HOLD_SELECT_POS      = 13;
  localparam int CPU_LEVEL_REPORT_POS        = 8;
  localparam int NESTING_DISABLE_POS         = 15;

  // ----------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] PRIORITY_RESET      = 3'h4;
  localparam logic [2:0] PRIORITY_OFF        = 3'h0;
  localparam logic [2:0] PRIORITY_TOP_USER   = 3'h7;
  localparam logic [3:0] CPU_LEVEL_USER_MAX  = 4'h7;
  localparam logic [3:0] TRAP_BASE_LEVEL     = 4'h8;
  localparam logic [7:0] STATUS_LOW_RESET    = 8'h00;
  localparam logic [7:0] VECTOR_BASE         = 8'h08;
  localparam logic [1:0] RESP_OKAY           = 2'h0;
  localparam logic [1:0] RESP_SLVERR         = 2'h2;

  // ----------------------------------------------------------------
  // Sources, in ascending vector order
  // ----------------------------------------------------------------
  localparam int NUM_SOURCES = 4;
  localparam int NUM_TRAPS   = 4;
  localparam int SRC_FIRST_UART_ERROR  = 0;
  localparam int SRC_SECOND_UART_ERROR = 1;
  localparam int SRC_VOLTAGE_DETECT    = 2;
  localparam int SRC_LOW_POWER_WAKEUP  = 3;
  localparam logic [7:0] SOURCE_VECTOR [NUM_SOURCES] = '{8'h51, 8'h52, 8'h5a, 8'h5c};
  localparam logic [7:0] TRAP_VECTOR_BASE = 8'h01;

  // ----------------------------------------------------------------
  // Saved context stack
  // ----------------------------------------------------------------
  localparam int STACK_WIDTH = 9;
  localparam int STACK_DEPTH = 16;
  localparam logic [4:0] STACK_DEPTH_MAX = 5'h10;

endpackage

// File: context_stack.sv
// Saved status stack with a registered top of stack
`timescale 1ns/1ps
`default_nettype none
module context_stack #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Stack operations
  input  wire logic             push,
  input  wire logic             pop,
  input  wire logic [WIDTH-1:0] push_data,
  output logic      [WIDTH-1:0] top_data
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    sp_q;
  logic [PW-1:0]    sp_below;

  assign sp_below = sp_q - {{(PW-1){1'b0}}, 1'b1};

  // ----------------------------------------------------------------
  // Pointer and top register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sp_q     <= '0;
      top_data <= '0;
    end
    else if (push)
    begin
      sp_q     <= sp_q + {{(PW-1){1'b0}}, 1'b1};
      top_data <= push_data;
    end
    else if (pop)
    begin
      sp_q     <= sp_below;
      top_data <= mem[sp_below];
    end
  end

  // Older entries sink into the array; the top lives in a register
  always_ff @(posedge aclk)
  begin
    if (push)
    begin
      mem[sp_q] <= top_data;
    end
  end

endmodule
`default_nettype wire

// File: interrupt_priority_status.sv
// Interrupt priority fields, arbitration, CPU level tracking and status report
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Three-bit priority, 7 highest, 0 disables
// - Every priority field resets to four
// - Unimplemented bits read zero, ignore writes
// - Bit 15 flags request held off
// - Bit 13 selects pending or acknowledged vector
// - Bits 11-8 report CPU level
// - Bits 6-0 give vector minus eight
// - Acknowledge only above current CPU level
// - Nesting disable blocks user pre-emption in service
// - Shared equal priorities still work correctly
// - Flag still set requests service again
// - Return restores status byte and level
// - Trap flag still set retakes trap
// - CPU level 7 masks all user interrupts
// - Traps at levels 8-11 never masked by user levels
// - Timed disable blocks levels 1-6 only
// - Small variant drops UART error fields
module interrupt_priority_status #(
  parameter bit SMALL_VARIANT = 1'b0
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write channels
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Peripheral sources and traps
  input  wire logic [3:0]  source_flag,
  input  wire logic [3:0]  source_enable,
  input  wire logic [3:0]  trap_flag,
  // Processor core
  output logic             irq_req,
  output logic [7:0]       irq_vector,
  output logic [3:0]       irq_level,
  input  wire logic        irq_ack,
  input  wire logic        return_from_interrupt,
  input  wire logic        status_write,
  input  wire logic [7:0]  status_wdata,
  input  wire logic        timed_disable_start,
  input  wire logic [13:0] timed_disable_cycles,
  output logic [7:0]       status_low_byte,
  output logic [3:0]       cpu_level
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [2:0]  level_q [4];
  logic        vector_hold_select_q;
  logic        nesting_disable_q;
  logic        ipl3_q;
  logic [4:0]  depth_q;
  logic [13:0] disable_cnt_q;
  logic [7:0]  acked_vector_q;
  logic        request_unacknowledged_q;
  logic [7:0]  pending_vector_q;
  logic [8:0]  stack_top;
  logic        take;
  logic        give_back;

  logic [7:0]  aw_addr_q;
  logic        aw_held_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        w_held_q;
  logic        do_write;

  assign cpu_level = {ipl3_q, status_low_byte[7:5]};
  assign take      = irq_ack && irq_req;
  assign give_back = return_from_interrupt && (depth_q != 5'h00) && !take;

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  logic [2:0] eff_level [4];
  logic       found_d;
  logic [3:0] best_level_d;
  logic [7:0] best_vector_d;
  logic       any_pending_d;
  logic [3:0] top_pend_level_d;
  logic [7:0] top_pend_vector_d;
  logic       user_blocked;

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      eff_level[i] = level_q[i];
    end
    if (SMALL_VARIANT)
    begin
      eff_level[interrupt_priority_status_pkg::SRC_FIRST_UART_ERROR]  = 3'h0;
      eff_level[interrupt_priority_status_pkg::SRC_SECOND_UART_ERROR] = 3'h0;
    end
  end

  // Nested service off: nothing user-level pre-empts a running handler
  assign user_blocked = nesting_disable_q && (depth_q != 5'h00);

  always_comb
  begin
    found_d           = 1'b0;
    best_level_d      = 4'h0;
    best_vector_d     = 8'h00;
    any_pending_d     = 1'b0;
    top_pend_level_d  = 4'h0;
    top_pend_vector_d = 8'h00;
    // Ascending vector scan with strict compare keeps the lowest vector on ties
    for (int i = 0; i < interrupt_priority_status_pkg::NUM_SOURCES; i++)
    begin
      if (source_flag[i] && source_enable[i]
          && eff_level[i] != interrupt_priority_status_pkg::PRIORITY_OFF)
      begin
        if (!any_pending_d || {1'b0, eff_level[i]} > top_pend_level_d)
        begin
          top_pend_level_d  = {1'b0, eff_level[i]};
          top_pend_vector_d = interrupt_priority_status_pkg::SOURCE_VECTOR[i];
        end
        any_pending_d = 1'b1;
        if ({1'b0, eff_level[i]} > cpu_level && !user_blocked
            && !(disable_cnt_q != 14'h0000
                 && eff_level[i] != interrupt_priority_status_pkg::PRIORITY_TOP_USER)
            && (!found_d || {1'b0, eff_level[i]} > best_level_d))
        begin
          found_d       = 1'b1;
          best_level_d  = {1'b0, eff_level[i]};
          best_vector_d = interrupt_priority_status_pkg::SOURCE_VECTOR[i];
        end
      end
    end
    // Traps sit above every user level and ignore every user mask
    for (int t = 0; t < interrupt_priority_status_pkg::NUM_TRAPS; t++)
    begin
      if (trap_flag[t]
          && interrupt_priority_status_pkg::TRAP_BASE_LEVEL + 4'(t) > cpu_level
          && (!found_d || interrupt_priority_status_pkg::TRAP_BASE_LEVEL + 4'(t) > best_level_d))
      begin
        found_d       = 1'b1;
        best_level_d  = interrupt_priority_status_pkg::TRAP_BASE_LEVEL + 4'(t);
        best_vector_d = interrupt_priority_status_pkg::TRAP_VECTOR_BASE + 8'(t);
      end
    end
  end

  // Request outputs are registered; a flag cleared now drops the request next cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_req                  <= 1'b0;
      irq_level                <= 4'h0;
      irq_vector               <= 8'h00;
      request_unacknowledged_q <= 1'b0;
      pending_vector_q         <= 8'h00;
    end
    else
    begin
      irq_req                  <= found_d && !take;
      irq_level                <= best_level_d;
      irq_vector               <= best_vector_d;
      request_unacknowledged_q <= any_pending_d && !found_d;
      pending_vector_q         <= top_pend_vector_d;
    end
  end

  // ----------------------------------------------------------------
  // CPU level, nesting and return
  // ----------------------------------------------------------------
  context_stack #(
    .WIDTH (interrupt_priority_status_pkg::STACK_WIDTH),
    .DEPTH (interrupt_priority_status_pkg::STACK_DEPTH)
  ) u_context_stack (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .push      (take),
    .pop       (give_back),
    .push_data ({status_low_byte, ipl3_q}),
    .top_data  (stack_top)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      status_low_byte <= interrupt_priority_status_pkg::STATUS_LOW_RESET;
      ipl3_q          <= 1'b0;
      depth_q         <= 5'h00;
      acked_vector_q  <= 8'h00;
    end
    else if (take)
    begin
      status_low_byte[7:5] <= irq_level[2:0];
      ipl3_q               <= irq_level[3];
      acked_vector_q       <= irq_vector;
      if (depth_q != interrupt_priority_status_pkg::STACK_DEPTH_MAX)
      begin
        depth_q <= depth_q + 5'h01;
      end
    end
    else if (give_back)
    begin
      status_low_byte <= stack_top[8:1];
      ipl3_q          <= stack_top[0];
      depth_q         <= depth_q - 5'h01;
    end
    else if (status_write)
    begin
      status_low_byte <= status_wdata;
    end
  end

  // Timed disable counts down once per clock
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      disable_cnt_q <= 14'h0000;
    end
    else if (timed_disable_start)
    begin
      disable_cnt_q <= timed_disable_cycles;
    end
    else if (disable_cnt_q != 14'h0000)
    begin
      disable_cnt_q <= disable_cnt_q - 14'h0001;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready  = !w_held_q;
  assign do_write      = aw_held_q && w_held_q && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q    <= 1'b0;
      w_held_q     <= 1'b0;
      aw_addr_q    <= 8'h00;
      w_data_q     <= 32'h0000_0000;
      w_strb_q     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= interrupt_priority_status_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !aw_held_q)
      begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_q)
      begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_addr_q)
          interrupt_priority_status_pkg::ADDR_UART_ERROR_PRIORITY,
          interrupt_priority_status_pkg::ADDR_VOLTAGE_DETECT_PRIORITY,
          interrupt_priority_status_pkg::ADDR_WAKEUP_PRIORITY,
          interrupt_priority_status_pkg::ADDR_INTERRUPT_STATUS_VECTOR,
          interrupt_priority_status_pkg::ADDR_INTERRUPT_CONTROL_ONE:
            s_axi_bresp <= interrupt_priority_status_pkg::RESP_OKAY;
          default:
            s_axi_bresp <= interrupt_priority_status_pkg::RESP_SLVERR;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Only the documented field bits are stored; every other bit is dropped
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < 4; i++)
      begin
        level_q[i] <= interrupt_priority_status_pkg::PRIORITY_RESET;
      end
      vector_hold_select_q <= 1'b0;
      nesting_disable_q    <= 1'b0;
    end
    else if (do_write)
    begin
      case (aw_addr_q)
        interrupt_priority_status_pkg::ADDR_UART_ERROR_PRIORITY:
        begin
          if (w_strb_q[1] && !SMALL_VARIANT)
            level_q[1] <= w_data_q[interrupt_priority_status_pkg::SECOND_UART_ERROR_LEVEL_POS +: 3];
          if (w_strb_q[0] && !SMALL_VARIANT)
            level_q[0] <= w_data_q[interrupt_priority_status_pkg::FIRST_UART_ERROR_LEVEL_POS +: 3];
        end
        interrupt_priority_status_pkg::ADDR_VOLTAGE_DETECT_PRIORITY:
          if (w_strb_q[0])
            level_q[2] <= w_data_q[interrupt_priority_status_pkg::VOLTAGE_DETECT_LEVEL_POS +: 3];
        interrupt_priority_status_pkg::ADDR_WAKEUP_PRIORITY:
          if (w_strb_q[0])
            level_q[3] <= w_data_q[interrupt_priority_status_pkg::LOW_POWER_WAKEUP_LEVEL_POS +: 3];
        interrupt_priority_status_pkg::ADDR_INTERRUPT_STATUS_VECTOR:
          if (w_strb_q[1])
            vector_hold_select_q <= w_data_q[interrupt_priority_status_pkg::VECTOR_HOLD_SELECT_POS];
        interrupt_priority_status_pkg::ADDR_INTERRUPT_CONTROL_ONE:
          if (w_strb_q[1])
            nesting_disable_q <= w_data_q[interrupt_priority_status_pkg::NESTING_DISABLE_POS];
        default:
          vector_hold_select_q <= vector_hold_select_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  logic [31:0] rdata_d;
  logic        rerr_d;
  logic [7:0]  shown_vector;

  // Hold off shows the live winner; otherwise the last taken vector
  assign shown_vector = vector_hold_select_q ? pending_vector_q : acked_vector_q;
  assign s_axi_arready = !s_axi_rvalid;

  always_comb
  begin
    rdata_d = 32'h0000_0000;
    rerr_d  = 1'b0;
    case (s_axi_araddr)
      interrupt_priority_status_pkg::ADDR_UART_ERROR_PRIORITY:
      begin
        rdata_d[interrupt_priority_status_pkg::SECOND_UART_ERROR_LEVEL_POS +: 3] = eff_level[1];
        rdata_d[interrupt_priority_status_pkg::FIRST_UART_ERROR_LEVEL_POS +: 3]  = eff_level[0];
      end
      interrupt_priority_status_pkg::ADDR_VOLTAGE_DETECT_PRIORITY:
        rdata_d[interrupt_priority_status_pkg::VOLTAGE_DETECT_LEVEL_POS +: 3] = level_q[2];
      interrupt_priority_status_pkg::ADDR_WAKEUP_PRIORITY:
        rdata_d[interrupt_priority_status_pkg::LOW_POWER_WAKEUP_LEVEL_POS +: 3] = level_q[3];
      interrupt_priority_status_pkg::ADDR_INTERRUPT_STATUS_VECTOR:
      begin
        rdata_d[interrupt_priority_status_pkg::REQUEST_UNACKNOWLEDGED_POS] =
          request_unacknowledged_q;
        rdata_d[interrupt_priority_status_pkg::VECTOR_HOLD_SELECT_POS] = vector_hold_select_q;
        rdata_d[interrupt_priority_status_pkg::CPU_LEVEL_REPORT_POS +: 4] = cpu_level;
        rdata_d[6:0] = 7'(shown_vector - interrupt_priority_status_pkg::VECTOR_BASE);
      end
      interrupt_priority_status_pkg::ADDR_INTERRUPT_CONTROL_ONE:
        rdata_d[interrupt_priority_status_pkg::NESTING_DISABLE_POS] = nesting_disable_q;
      default:
        rerr_d = 1'b1;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= interrupt_priority_status_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdata_d;
      s_axi_rresp  <= rerr_d ? interrupt_priority_status_pkg::RESP_SLVERR
                             : interrupt_priority_status_pkg::RESP_OKAY;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_taken;
    irq_ack && irq_req;
  endsequence

  a_reset_priority: assert property (@(posedge aclk)
    $past(!aresetn) && aresetn |-> level_q[2] == 3'h4 && level_q[3] == 3'h4)
    else $error("priority field not four after reset");
  a_above_cpu_level: assert property (@(posedge aclk) disable iff (!aresetn)
    irq_req && $past(aresetn) |-> irq_level > $past(cpu_level))
    else $error("request not above cpu level");
  a_level_raised: assert property (@(posedge aclk) disable iff (!aresetn)
    s_taken |=> cpu_level == $past(irq_level) && !irq_req)
    else $error("take did not raise cpu level");
  a_return_restore: assert property (@(posedge aclk) disable iff (!aresetn)
    give_back |=> status_low_byte == $past(stack_top[8:1]) && ipl3_q == $past(stack_top[0]))
    else $error("return did not restore status");
  a_timed_block: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(disable_cnt_q != 14'h0000) && irq_req |-> irq_level >= 4'h7)
    else $error("timed disable leaked low level");
  a_mask_seven: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(cpu_level >= 4'h7) && irq_req |-> irq_level >= 4'h8)
    else $error("level seven did not mask user");
  a_nest_block: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(user_blocked) && irq_req |-> irq_level >= 4'h8)
    else $error("nesting disable failed");
  a_trap_taken: assert property (@(posedge aclk) disable iff (!aresetn)
    trap_flag[3] && cpu_level < 4'hb && !take |=> irq_req ##0 irq_level >= 4'hb)
    else $error("trap masked");
  a_zero_disables: assert property (@(posedge aclk) disable iff (!aresetn)
    (eff_level[0] == 3'h0 && eff_level[1] == 3'h0 && eff_level[2] == 3'h0
     && eff_level[3] == 3'h0 && trap_flag == 4'h0) |=> !irq_req)
    else $error("disabled source requested");
  a_unacked_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    request_unacknowledged_q |-> !irq_req)
    else $error("held-off flag with live request");
  a_read_reserved: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000 && s_axi_rdata[14] == 1'b0)
    else $error("unimplemented bits read nonzero");

endmodule
`default_nettype wire

// File: core_model.sv
// Processor core model that takes offered interrupt requests
`timescale 1ns/1ps
`default_nettype none
module core_model (
  // Clock and request handshake
  input  wire logic aclk,
  input  wire logic irq_req,
  input  wire logic take_en,
  output var  logic irq_ack
);
  // ----------------------------------------
  // Acknowledge
  // ----------------------------------------
  // One-cycle pulse only on a seen request, so a stale ack never lands
  always @(posedge aclk)
    irq_ack <= irq_req & take_en & !irq_ack;
endmodule
`default_nettype wire

// File: tb_top.sv
// Self-checking testbench for the interrupt priority and status block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ----------------------------------------
  // Signals, clock and instances
  // ----------------------------------------
  logic aclk = 1'h0, aresetn = 1'h0, take_en = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic return_from_interrupt = 1'h0, status_write = 1'h0, timed_disable_start = 1'h0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, status_wdata = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf, source_flag = '0, source_enable = '0, trap_flag = '0;
  logic [13:0] timed_disable_cycles = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic irq_req, irq_ack;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0] irq_vector, status_low_byte;
  logic [3:0] irq_level, cpu_level;
  int fails = 0, compares = 0;

  always #12.5 aclk = ~aclk;
  interrupt_priority_status u_interrupt_priority_status (.*);
  core_model u_core_model (.aclk(aclk), .irq_req(irq_req), .take_en(take_en), .irq_ack(irq_ack));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic oops;
    fails++;
    finish_test();
  endtask

  // Checks land at the falling edge, clear of the design's updates
  task automatic cyc(input int n);
    repeat (n) @(negedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ah, wh, bh;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    bh = 1'h0;
    for (int n = 0; n < 40 && !bh; n++)
    begin
      @(negedge aclk);
      ah = s_axi_awvalid & s_axi_awready;
      wh = s_axi_wvalid & s_axi_wready;
      bh = s_axi_bvalid;
      if (bh) chk(s_axi_bresp, r);
      @(posedge aclk);
      s_axi_awvalid <= s_axi_awvalid & !ah;
      s_axi_wvalid <= s_axi_wvalid & !wh;
      s_axi_bready <= !bh;
    end
    if (!bh) oops();
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    logic ah, rh;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    rh = 1'h0;
    for (int n = 0; n < 40 && !rh; n++)
    begin
      @(negedge aclk);
      ah = s_axi_arvalid & s_axi_arready;
      rh = s_axi_rvalid;
      if (rh) chk(s_axi_rdata, e);
      if (rh) chk(s_axi_rresp, r);
      @(posedge aclk);
      s_axi_arvalid <= s_axi_arvalid & !ah;
      s_axi_rready <= !rh;
    end
    if (!rh) oops();
  endtask

  task automatic t_regs;
    rd(8'h00, 32'h440, 2'h0);
    rd(8'h08, 32'h4, 2'h0);
    rd(8'h0c, 32'h78, 2'h0);
    wr(8'h00, 32'hffffffff, 2'h0);
    rd(8'h00, 32'h770, 2'h0);
    wr(8'h20, 32'h1, 2'h2);
    rd(8'h20, 32'h0, 2'h2);
    $display("test regs done");
  endtask

  task automatic t_ack;
    wr(8'h00, 32'h50, 2'h0);
    wr(8'h04, 32'h3, 2'h0);
    @(posedge aclk);
    source_enable <= 4'h5;
    source_flag <= 4'h1;
    take_en <= 1'h1;
    cyc(6);
    chk(cpu_level, 4'h5);
    @(posedge aclk);
    source_flag <= 4'h5;
    cyc(3);
    chk(irq_req, 1'h0);
    rd(8'h0c, 32'h8549, 2'h0);
    @(posedge aclk);
    take_en <= 1'h0;
    return_from_interrupt <= 1'h1;
    @(posedge aclk);
    return_from_interrupt <= 1'h0;
    cyc(3);
    chk(cpu_level, 4'h0);
    chk(irq_vector, 8'h51);
    @(posedge aclk);
    source_flag <= 4'h4;
    cyc(3);
    chk(irq_level, 4'h3);
    wr(8'h0c, 32'h2000, 2'h0);
    rd(8'h0c, 32'h2052, 2'h0);
    $display("test ack done");
  endtask

  task automatic t_mask;
    wr(8'h00, 32'h70, 2'h0);
    @(posedge aclk);
    status_write <= 1'h1;
    status_wdata <= 8'he0;
    source_enable <= 4'h1;
    source_flag <= 4'h1;
    @(posedge aclk);
    status_write <= 1'h0;
    cyc(3);
    chk(irq_req, 1'h0);
    @(posedge aclk);
    trap_flag <= 4'h1;
    cyc(3);
    chk(irq_level, 4'h8);
    @(posedge aclk);
    trap_flag <= 4'h0;
    status_write <= 1'h1;
    status_wdata <= 8'h00;
    @(posedge aclk);
    status_write <= 1'h0;
    timed_disable_start <= 1'h1;
    timed_disable_cycles <= 14'h64;
    @(posedge aclk);
    timed_disable_start <= 1'h0;
    cyc(3);
    chk(irq_level, 4'h7);
    wr(8'h00, 32'h660, 2'h0);
    @(posedge aclk);
    source_flag <= 4'h3;
    source_enable <= 4'h3;
    cyc(3);
    chk(irq_req, 1'h0);
    cyc(100);
    chk(irq_vector, 8'h51);
    wr(8'h00, 32'h600, 2'h0);
    cyc(3);
    chk(irq_vector, 8'h52);
    $display("test mask done");
  endtask

  // Nesting off: a higher user level waits, a trap still gets through
  task automatic t_nest;
    wr(8'h04, 32'h7, 2'h0);
    wr(8'h10, 32'h8000, 2'h0);
    rd(8'h10, 32'h8000, 2'h0);
    @(posedge aclk);
    take_en <= 1'h1;
    cyc(6);
    chk(status_low_byte, 8'hc0);
    @(posedge aclk);
    take_en <= 1'h0;
    source_flag <= 4'h6;
    source_enable <= 4'h6;
    cyc(3);
    chk(irq_req, 1'h0);
    @(posedge aclk);
    trap_flag <= 4'h8;
    cyc(3);
    chk(irq_level, 4'hb);
    @(posedge aclk);
    trap_flag <= 4'h0;
    return_from_interrupt <= 1'h1;
    @(posedge aclk);
    return_from_interrupt <= 1'h0;
    cyc(3);
    chk(status_low_byte, 8'h00);
    chk(irq_vector, 8'h5a);
    $display("test nest done");
  endtask

  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs();
    t_ack();
    t_mask();
    t_nest();
    finish_test();
  end
endmodule
`default_nettype wire
